// *** design/rsf_pkg.sv ***
// Package for the reset state and flag logic: constants, types, register map.
// Assumes a single 100 MHz clock and an AXI4-Lite register bus.
package rsf_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_WDOG = 8'h08;
  localparam logic [7:0] ADDR_SUPPLY = 8'h0C;
  localparam logic [7:0] ADDR_PORT = 8'h10;
  localparam logic [7:0] ADDR_TIMER = 8'h14;
  localparam logic [7:0] ADDR_CORE = 8'h18;
  localparam logic [7:0] ADDR_EVENTS = 8'h1C;
  localparam logic [7:0] ADDR_MASK = 8'h20;
  localparam logic [7:0] ADDR_CMD = 8'h24;
  // Power-on values, and the stack pointer after a halted watchdog reset (SP_ZERO)
  localparam logic [7:0] WDOG_POR = 8'h53;
  localparam logic [7:0] SUPPLY_POR = 8'h55;
  localparam logic [7:0] PORT_POR = 8'hFF;
  localparam logic [7:0] TIMER_POR = 8'h00;
  localparam logic [7:0] PCL_POR = 8'h00;
  localparam logic [3:0] ANALOG_POR = 4'hF;
  localparam logic [2:0] SP_TOP = 3'h7;
  localparam logic [2:0] SP_ZERO = 3'h0;
  // Watchdog control codes in bits 7:3
  localparam logic [4:0] WDOG_DISABLE = 5'h15;
  localparam logic [4:0] WDOG_ENABLE = 5'h0A;
  // Defined supply threshold codes
  localparam logic [7:0] SUPPLY_V0 = 8'h55;
  localparam logic [7:0] SUPPLY_V1 = 8'h33;
  localparam logic [7:0] SUPPLY_V2 = 8'h99;
  localparam logic [7:0] SUPPLY_V3 = 8'hAA;
  // Delay before a bad-select reset, in slow oscillator cycles
  localparam int SEL_DELAY_SLOW = 2;
  // Slow oscillator of 32 kHz as a divider of the 100 MHz clock
  localparam int CLK_HZ = 100000000;
  localparam int SLOW_HZ = 32000;
  localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
  localparam int WDOG_W = 16;
  // Event bits
  localparam int EV_POR = 0;
  localparam int EV_LOWV = 1;
  localparam int EV_WDT = 2;
  localparam int EV_WCTL = 3;
  localparam int EV_SEL = 4;
  localparam int EV_W = 5;

  typedef enum logic [2:0] {
    RSF_RUN = 3'b001,
    RSF_HOLD = 3'b010,
    RSF_APPLY = 3'b100
  } rsf_state_t;

  typedef enum logic [3:0] {
    RSF_SRC_NONE = 4'b0000,
    RSF_SRC_LOWV = 4'b0001,
    RSF_SRC_WDT = 4'b0010,
    RSF_SRC_WCTL = 4'b0100,
    RSF_SRC_SEL = 4'b1000
  } rsf_src_t;

  typedef struct packed {
    logic [7:0] port_data_reg;
    logic [7:0] port_direction_reg;
    logic [3:0] analog_channel_pins;
    logic [7:0] timer_ctrl;
    logic [7:0] timer_data;
    logic timer_on;
    logic int_enable;
    logic [7:0] program_counter_low;
    logic [2:0] stack_ptr;
  } rsf_core_t;
endpackage

// *** design/rsf_divider.sv ***
// Divider that makes the slow internal oscillator tick as a one-cycle enable.
// Assumes the single system clock and synchronous active-low reset.
module rsf_divider #(
  parameter int DIV = rsf_pkg::SLOW_DIV
) (
  input wire logic mclk,
  input wire logic rst_n,
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } rsf_div_t;
  rsf_div_t q;
  rsf_div_t next_q;

  always_comb begin
    next_q = q;
    next_q.tick = 1'b0;
    if (q.cnt == 16'(DIV - 1)) begin
      next_q.cnt = 16'h0000;
      next_q.tick = 1'b1;
    end else begin
      next_q.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick = q.tick;
endmodule

// *** design/rsf_reset_flags.sv ***
// Reset state and flag logic: reset sources, status flags, initial core state.
// Assumes an AXI4-Lite master on the register side and the core reading core_state.
module rsf_reset_flags #(
  parameter int WDOG_LIMIT = 50000,
  parameter int SEL_DELAY = rsf_pkg::SEL_DELAY_SLOW
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic low_supply_reset,
  input wire logic halted,
  input wire logic wdog_kick,
  output rsf_pkg::rsf_core_t core_state,
  output logic core_reset,
  output logic watchdog_timeout_flag,
  output logic power_down_flag,
  output logic irq,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    rsf_pkg::rsf_state_t st;
    rsf_pkg::rsf_src_t src;
    logic src_halted;
    rsf_pkg::rsf_core_t core;
    logic to_flag;
    logic pd_flag;
    logic lowv_flag;
    logic sel_flag;
    logic wctl_flag;
    logic [7:0] wdog_ctrl;
    logic [7:0] supply_sel;
    logic [rsf_pkg::WDOG_W-1:0] wdog_cnt;
    logic [1:0] sel_cnt;
    logic [rsf_pkg::EV_W-1:0] events;
    logic [rsf_pkg::EV_W-1:0] mask;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
    logic pwr_done;
  } rsf_regs_t;

  rsf_regs_t q;
  rsf_regs_t next_q;
  logic slow_tick;

  rsf_divider #(
    .DIV(rsf_pkg::SLOW_DIV)
  ) rsf_divider_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(slow_tick)
  );

  function automatic logic supply_code_ok(input logic [7:0] v);
    return v == rsf_pkg::SUPPLY_V0 || v == rsf_pkg::SUPPLY_V1 ||
           v == rsf_pkg::SUPPLY_V2 || v == rsf_pkg::SUPPLY_V3;
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    return a <= rsf_pkg::ADDR_CMD && a[1:0] == 2'b00;
  endfunction

  function automatic rsf_pkg::rsf_core_t core_por();
    rsf_pkg::rsf_core_t c;
    c.port_data_reg = rsf_pkg::PORT_POR;
    c.port_direction_reg = rsf_pkg::PORT_POR;
    c.analog_channel_pins = rsf_pkg::ANALOG_POR;
    c.timer_ctrl = rsf_pkg::TIMER_POR;
    c.timer_data = rsf_pkg::TIMER_POR;
    c.timer_on = 1'b0;
    c.int_enable = 1'b0;
    c.program_counter_low = rsf_pkg::PCL_POR;
    c.stack_ptr = rsf_pkg::SP_TOP;
    return c;
  endfunction

  logic wdog_run;
  logic wdog_expire;
  logic wctl_bad;
  logic sel_bad;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wb;
  logic [7:0] rd_addr;
  logic [rsf_pkg::EV_W-1:0] ev_new;

  assign wdog_run = q.wdog_ctrl[7:3] != rsf_pkg::WDOG_DISABLE;
  assign wdog_expire = wdog_run && q.wdog_cnt == rsf_pkg::WDOG_W'(WDOG_LIMIT - 1);
  assign wctl_bad = q.wdog_ctrl[7:3] != rsf_pkg::WDOG_DISABLE &&
                    q.wdog_ctrl[7:3] != rsf_pkg::WDOG_ENABLE;
  assign sel_bad = !supply_code_ok(q.supply_sel);
  assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
  assign rd_fire = s_axi_arvalid && !q.rvalid;
  assign wb = q.w_data[7:0];
  assign rd_addr = s_axi_araddr[7:0];
  // Event raised by the reset being applied now; it must survive a clearing read
  assign ev_new = (q.st != rsf_pkg::RSF_APPLY) ? '0 :
                  {q.src == rsf_pkg::RSF_SRC_SEL, q.src == rsf_pkg::RSF_SRC_WCTL,
                   q.src == rsf_pkg::RSF_SRC_WDT, q.src == rsf_pkg::RSF_SRC_LOWV, 1'b0};

  always_comb begin
    next_q = q;
    next_q.wdog_cnt = q.wdog_cnt;
    if (!q.aw_got && s_axi_awvalid) begin
      next_q.aw_got = 1'b1;
      next_q.aw_addr = s_axi_awaddr[7:0];
    end
    if (!q.w_got && s_axi_wvalid) begin
      next_q.w_got = 1'b1;
      next_q.w_data = s_axi_wdata;
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    // Watchdog counter, restarted by a kick
    if (wdog_kick || !wdog_run) begin
      next_q.wdog_cnt = '0;
    end else if (q.st == rsf_pkg::RSF_RUN) begin
      next_q.wdog_cnt = q.wdog_cnt + 1'b1;
    end
    // Bad select code counts slow ticks before resetting
    if (!sel_bad) begin
      next_q.sel_cnt = 2'h0;
    end else if (slow_tick && q.sel_cnt != 2'(SEL_DELAY)) begin
      next_q.sel_cnt = q.sel_cnt + 2'h1;
    end
    unique case (q.st)
      rsf_pkg::RSF_RUN: begin
        next_q.src = rsf_pkg::RSF_SRC_NONE;
        if (low_supply_reset && !halted) begin
          next_q.src = rsf_pkg::RSF_SRC_LOWV;
        end else if (sel_bad && q.sel_cnt == 2'(SEL_DELAY) && slow_tick) begin
          next_q.src = rsf_pkg::RSF_SRC_SEL;
        end else if (wctl_bad) begin
          next_q.src = rsf_pkg::RSF_SRC_WCTL;
        end else if (wdog_expire) begin
          next_q.src = rsf_pkg::RSF_SRC_WDT;
        end
        if (next_q.src != rsf_pkg::RSF_SRC_NONE) begin
          next_q.st = rsf_pkg::RSF_HOLD;
          next_q.src_halted = halted;
        end
      end
      rsf_pkg::RSF_HOLD: begin
        if (!low_supply_reset) begin
          next_q.st = rsf_pkg::RSF_APPLY;
        end
      end
      rsf_pkg::RSF_APPLY: begin
        next_q.st = rsf_pkg::RSF_RUN;
        next_q.wdog_cnt = '0;
        unique case (q.src)
          rsf_pkg::RSF_SRC_LOWV: begin
            next_q.lowv_flag = 1'b1;
            next_q.events[rsf_pkg::EV_LOWV] = 1'b1;
            next_q.core.program_counter_low = rsf_pkg::PCL_POR;
          end
          rsf_pkg::RSF_SRC_SEL: begin
            next_q.sel_flag = 1'b1;
            next_q.supply_sel = rsf_pkg::SUPPLY_POR;
            next_q.events[rsf_pkg::EV_SEL] = 1'b1;
            next_q.core.program_counter_low = rsf_pkg::PCL_POR;
          end
          rsf_pkg::RSF_SRC_WCTL: begin
            next_q.wctl_flag = 1'b1;
            next_q.core = core_por();
            next_q.wdog_ctrl = rsf_pkg::WDOG_POR;
            next_q.to_flag = 1'b1;
            next_q.events[rsf_pkg::EV_WCTL] = 1'b1;
          end
          rsf_pkg::RSF_SRC_WDT: begin
            next_q.events[rsf_pkg::EV_WDT] = 1'b1;
            next_q.to_flag = 1'b1;
            if (q.src_halted) begin
              next_q.pd_flag = 1'b1;
              next_q.core.program_counter_low = rsf_pkg::PCL_POR;
              next_q.core.stack_ptr = rsf_pkg::SP_ZERO;
            end else begin
              next_q.core = core_por();
              next_q.wdog_ctrl = rsf_pkg::WDOG_POR;
            end
          end
          default: begin
            next_q.core.program_counter_low = q.core.program_counter_low;
          end
        endcase
      end
      default: begin
        next_q.st = rsf_pkg::RSF_RUN;
      end
    endcase
    if (halted && q.st == rsf_pkg::RSF_RUN && next_q.st == rsf_pkg::RSF_RUN) begin
      next_q.pd_flag = 1'b1;
    end
    next_q.pwr_done = 1'b1;
    // Register writes; hardware sets win over software clears
    if (wr_fire) begin
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = addr_known(q.aw_addr) ? 2'b00 : 2'b10;
      if (q.w_data[7:0] != 8'h00 || 1'b1) begin
        unique case (q.aw_addr)
          rsf_pkg::ADDR_CTRL: begin
            if (s_axi_wstrb[0] || q.w_data[31]) begin
              next_q.lowv_flag = next_q.lowv_flag & (wb[2] | q.st == rsf_pkg::RSF_APPLY);
              next_q.sel_flag = next_q.sel_flag & (wb[1] | q.st == rsf_pkg::RSF_APPLY);
              next_q.wctl_flag = next_q.wctl_flag & (wb[0] | q.st == rsf_pkg::RSF_APPLY);
            end
          end
          rsf_pkg::ADDR_WDOG: next_q.wdog_ctrl = wb;
          rsf_pkg::ADDR_SUPPLY: next_q.supply_sel = wb;
          rsf_pkg::ADDR_PORT: begin
            next_q.core.port_data_reg = wb;
            next_q.core.port_direction_reg = q.w_data[15:8];
            next_q.core.analog_channel_pins = q.w_data[19:16];
          end
          rsf_pkg::ADDR_TIMER: begin
            next_q.core.timer_ctrl = wb;
            next_q.core.timer_data = q.w_data[15:8];
            next_q.core.timer_on = q.w_data[16];
          end
          rsf_pkg::ADDR_MASK: next_q.mask = q.w_data[rsf_pkg::EV_W-1:0];
          rsf_pkg::ADDR_CMD: begin
            next_q.core.int_enable = q.w_data[0];
            if (q.st == rsf_pkg::RSF_RUN) begin
              next_q.to_flag = next_q.to_flag & ~q.w_data[1];
              next_q.pd_flag = next_q.pd_flag & (~q.w_data[2] | halted);
            end
          end
          default: next_q.bresp = next_q.bresp;
        endcase
      end
    end
    if (rd_fire) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = addr_known(rd_addr) ? 2'b00 : 2'b10;
      next_q.rdata = 32'h0000_0000;
      unique case (rd_addr)
        rsf_pkg::ADDR_STATUS: next_q.rdata = {30'h0, q.to_flag, q.pd_flag};
        rsf_pkg::ADDR_CTRL: next_q.rdata = {29'h0, q.lowv_flag, q.sel_flag, q.wctl_flag};
        rsf_pkg::ADDR_WDOG: next_q.rdata = {24'h0, q.wdog_ctrl};
        rsf_pkg::ADDR_SUPPLY: next_q.rdata = {24'h0, q.supply_sel};
        rsf_pkg::ADDR_PORT: next_q.rdata = {12'h0, q.core.analog_channel_pins,
                                            q.core.port_direction_reg, q.core.port_data_reg};
        rsf_pkg::ADDR_TIMER: next_q.rdata = {15'h0, q.core.timer_on, q.core.timer_data,
                                             q.core.timer_ctrl};
        rsf_pkg::ADDR_CORE: next_q.rdata = {13'h0, q.core.stack_ptr, q.core.int_enable,
                                            7'h00, q.core.program_counter_low};
        rsf_pkg::ADDR_EVENTS: begin
          next_q.rdata = {27'h0, q.events};
          // Read clears, but an event landing now survives
          next_q.events = (next_q.events & ~q.events) | ev_new;
        end
        rsf_pkg::ADDR_MASK: next_q.rdata = {27'h0, q.mask};
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= rsf_pkg::RSF_RUN;
      q.src <= rsf_pkg::RSF_SRC_NONE;
      q.core <= core_por();
      q.wdog_ctrl <= rsf_pkg::WDOG_POR;
      q.supply_sel <= rsf_pkg::SUPPLY_POR;
      q.events <= 5'h01;
    end else begin
      q <= next_q;
    end
  end

  assign core_state = q.core;
  assign core_reset = q.st != rsf_pkg::RSF_RUN;
  assign watchdog_timeout_flag = q.to_flag;
  assign power_down_flag = q.pd_flag;
  assign irq = |(q.events & q.mask);
  assign s_axi_awready = !q.aw_got;
  assign s_axi_wready = !q.w_got;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
endmodule

// *** dv/rsf_reset_flags_chk.sv ***
// Checker for the reset state and flag logic, bound to its top module.
// Assumes only the top module's ports are visible.
module rsf_reset_flags_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic low_supply_reset,
  input wire logic halted,
  input wire rsf_pkg::rsf_core_t core_state,
  input wire logic core_reset,
  input wire logic watchdog_timeout_flag,
  input wire logic power_down_flag,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_por_flags;
    $rose(rst_n) |-> !watchdog_timeout_flag && !power_down_flag;
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("flags not cleared");
  property p_por_int;
    $rose(rst_n) |-> !core_state.int_enable;
  endproperty
  a_por_int: assert property (p_por_int) else $error("interrupts left on");
  property p_por_timer;
    $rose(rst_n) |-> core_state.timer_ctrl == 8'h00 && core_state.timer_data == 8'h00
      && !core_state.timer_on;
  endproperty
  a_por_timer: assert property (p_por_timer) else $error("timer not off");
  property p_por_port;
    $rose(rst_n) |-> core_state.port_data_reg == 8'hFF && core_state.port_direction_reg == 8'hFF
      && core_state.analog_channel_pins == 4'hF;
  endproperty
  a_por_port: assert property (p_por_port) else $error("port not input");
  property p_por_core;
    $rose(rst_n) |-> core_state.stack_ptr == 3'h7 && core_state.program_counter_low == 8'h00;
  endproperty
  a_por_core: assert property (p_por_core) else $error("stack or counter wrong");
  property p_lowv_keep;
    core_reset && low_supply_reset |=> $stable(watchdog_timeout_flag) && $stable(power_down_flag);
  endproperty
  a_lowv_keep: assert property (p_lowv_keep) else $error("flags moved");
  property p_halt_wdt;
    $fell(core_reset) && halted |-> watchdog_timeout_flag && power_down_flag
      && core_state.program_counter_low == 8'h00 && core_state.stack_ptr == 3'h0;
  endproperty
  a_halt_wdt: assert property (p_halt_wdt) else $error("halted reset wrong");
  property p_run_wdt;
    $fell(core_reset) && !halted && $rose(watchdog_timeout_flag) |->
      power_down_flag == $past(power_down_flag) && core_state.stack_ptr == 3'h7
      && !core_state.int_enable && !core_state.timer_on;
  endproperty
  a_run_wdt: assert property (p_run_wdt) else $error("running reset wrong");
  c_halt: cover property ($fell(core_reset) && halted);
  c_run: cover property ($fell(core_reset) && $rose(watchdog_timeout_flag));
  c_irq: cover property ($rose(irq));
endmodule

bind rsf_reset_flags rsf_reset_flags_chk rsf_reset_flags_chk_i (.mclk, .rst_n, .low_supply_reset,
  .halted, .core_state, .core_reset, .watchdog_timeout_flag, .power_down_flag, .irq);

// *** dv/rsf_core_model.sv ***
// Core model: kicks the watchdog and sleeps on request.
// Assumes the bench steers it through kick_en and halt_req.
module rsf_core_model (
  input wire logic mclk,
  input wire logic core_reset,
  input wire logic kick_en,
  input wire logic halt_req,
  output logic halted = 1'b0,
  output logic wdog_kick = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt = 3'h0;
  always @(posedge mclk) begin
    cnt <= cnt + 3'h1;
    halted <= halt_req;
    // A sleeping or resetting core runs no code, so it cannot kick
    wdog_kick <= kick_en && !core_reset && !halted && cnt == 3'h0;
  end
endmodule

// *** dv/rsf_reset_flags_test.sv ***
// Testbench for the reset state and flag logic; reads checked from a queue.
// Assumes the core model drives halted and the watchdog kick.
module rsf_reset_flags_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SLOW = rsf_pkg::SLOW_DIV;
  localparam logic [7:0] POR_A [8] = '{8'h00, 8'h18, 8'h10, 8'h14, 8'h08, 8'h0C, 8'h1C, 8'h1C};
  localparam logic [31:0] POR_D [8] = '{32'h0, 32'h0007_0000, 32'h000F_FFFF, 32'h0,
    32'h53, 32'h55, 32'h1, 32'h0};
  logic mclk = 1'b0, rst_n = 1'b0, lowv = 1'b0, kick_en = 1'b1, halt_req = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, lfsr = 32'h9B9D;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, halted, kick, core_reset, to, pd, irq;
  rsf_pkg::rsf_core_t core_state;
  logic [65:0] exp_q[$];
  logic [65:0] exp_e;
  int error_cnt = 0, check_count = 0, n;
  rsf_reset_flags #(.WDOG_LIMIT(20)) rsf_reset_flags_i (.mclk(mclk), .rst_n(rst_n),
    .low_supply_reset(lowv), .halted(halted), .wdog_kick(kick), .core_state(core_state),
    .core_reset(core_reset), .watchdog_timeout_flag(to), .power_down_flag(pd), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  rsf_core_model rsf_core_model_i (.mclk(mclk), .core_reset(core_reset), .kick_en(kick_en),
    .halt_req(halt_req), .halted(halted), .wdog_kick(kick));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic fail(input string m);
    error_cnt++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic check_word(input logic [31:0] got, e, m, input logic [1:0] gr, er);
    check_count++;
    if (((got & m) !== (e & m)) || (gr !== er)) fail($sformatf("read %h expected %h", got, e));
  endtask
  task automatic check_bit(input logic got, e);
    check_count++;
    if (got !== e) fail("flag mismatch");
  endtask
  task automatic check_irq(input logic e);
    repeat (2) @(negedge mclk);
    check_count++;
    if (irq !== e) fail("irq mismatch");
  endtask
  task automatic check_resp(input logic [1:0] got, e);
    check_count++;
    if (got !== e) fail("write response mismatch");
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Handshakes are judged on the falling edge, where ready and valid have settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] br;
    n = 0;
    br = 2'b00;
    @(posedge mclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge mclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid === 1'b1;
      br = bresp;
      @(posedge mclk);
      n++;
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end while (!b_hs && n < 100);
    bready <= 1'b0;
    if (n >= 100) fail("write hang");
    else check_resp(br, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r = 2'b00);
    logic ar_hs, r_hs;
    exp_q.push_back({r, m, e});
    n = 0;
    @(posedge mclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge mclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid === 1'b1;
      @(posedge mclk);
      n++;
      if (ar_hs) arvalid <= 1'b0;
    end while (!r_hs && n < 100);
    rready <= 1'b0;
    if (n >= 100) fail("read hang");
  endtask
  always @(negedge mclk) begin
    if (rvalid && rready) begin
      exp_e = exp_q.pop_front();
      check_word(rdata, exp_e[31:0], exp_e[63:32], rresp, exp_e[65:64]);
    end
  end
  task automatic wait_rst(input int lim, output int t);
    t = 0;
    @(negedge mclk);
    while (!core_reset && t < lim) begin
      @(negedge mclk);
      t++;
    end
    n = 0;
    while (core_reset && n < 100) begin
      @(negedge mclk);
      n++;
    end
    if (t >= lim || n >= 100) fail("reset hang");
    @(posedge mclk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #300000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    int t;
    logic [31:0] pv, tv;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (POR_A[i]) rd(POR_A[i], POR_D[i], '1);
    rd(8'h28, 32'h0, '1, 2'b10);
    wr(8'h28, 32'h0, 2'b10);
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      pv = lfsr & 32'h000F_FFFF;
      tv = lfsr_next(lfsr) & 32'h0001_FFFF;
      wr(8'h10, pv);
      wr(8'h14, tv);
      rd(8'h10, pv, '1);
      rd(8'h14, tv, '1);
    end
    wr(8'h24, 32'h1);
    rd(8'h18, 32'h0007_8000, '1);
    kick_en <= 1'b0;
    wait_rst(200, t);
    kick_en <= 1'b1;
    rd(8'h00, 32'h2, '1);
    rd(8'h18, 32'h0007_0000, '1);
    rd(8'h10, 32'h000F_FFFF, '1);
    rd(8'h14, 32'h0, '1);
    lowv <= 1'b1;
    repeat (10) @(posedge mclk);
    lowv <= 1'b0;
    wait_rst(20, t);
    rd(8'h00, 32'h2, '1);
    rd(8'h04, 32'h4, 32'h4);
    wr(8'h04, 32'h0);
    wr(8'h24, 32'h2);
    rd(8'h04, 32'h0, 32'h4);
    wr(8'h20, 32'h0);
    check_irq(1'b0);
    wr(8'h20, 32'h1F);
    check_irq(1'b1);
    rd(8'h1C, 32'h2, 32'h2);
    check_irq(1'b0);
    wr(8'h24, 32'h1);
    wr(8'h10, 32'h000A_1234);
    halt_req <= 1'b1;
    wait_rst(200, t);
    halt_req <= 1'b0;
    rd(8'h00, 32'h3, '1);
    rd(8'h18, 32'h0000_8000, '1);
    rd(8'h10, 32'h000A_1234, '1);
    check_irq(1'b1);
    rd(8'h1C, 32'h4, 32'h4);
    check_irq(1'b0);
    wr(8'h08, 32'hFF);
    wait_rst(100, t);
    rd(8'h04, 32'h1, 32'h1);
    rd(8'h08, 32'h53, '1);
    // Disable code stops the watchdog; a defined select code causes no reset
    wr(8'h08, 32'hAB);
    kick_en <= 1'b0;
    repeat (40) @(negedge mclk);
    check_bit(core_reset, 1'b0);
    wr(8'h0C, 32'h33);
    wr(8'h08, 32'h53);
    kick_en <= 1'b1;
    rd(8'h0C, 32'h33, '1);
    wr(8'h0C, 32'h12);
    wait_rst(4 * SLOW, t);
    check_bit(t >= 2 * SLOW - 10 && t <= 3 * SLOW + 10, 1'b1);
    rd(8'h04, 32'h2, 32'h2);
    rd(8'h0C, 32'h55, '1);
    report_and_stop();
  end
endmodule
